//--- src/dmc_ddr_cfg.sv
// Mode configuration, burst ordering and read latency of the DRAM
// How it works
// - Load with banks 0,0 writes base register
// - Load with bank lo set, hi clear writes extended
// - Base fields: length, type, latency, mode
// - Address bit 3 picks burst type
// - Low column bits start, upper pick block
// - Sequential adds one, wraps in block
// - Interleaved offset is start xor k
// - Read latency 2, 2.5 or 3 clocks
// - First data at edge n plus m
// - Mode zero is normal operation
// - Mode bit 8 alone starts DLL reset
// - DLL reset bit clears itself
// - Extended: DLL off, drive, isolation
// - Extended register holds until rewritten
// - Self refresh turns DLL off, back on
// - Isolation output off when not accessed
`timescale 1ns/1ps
`include "dmc_params.svh"
module dmc_ddr_cfg
	import dmc_pkg::*;
#(
	parameter int LOCK_CLKS = `DMC_LOCK_CLKS
) (
	// Register side clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Link clock and command pins
	input  wire logic        ck,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic        cke,
	input  wire logic        bank_select_lo,
	input  wire logic        bank_select_hi,
	input  wire logic [12:0] address_inputs,
	// Link side outputs
	output logic             rd_data_valid,
	output logic             rd_half_phase,
	output logic [2:0]       col_offset,
	output logic             module_isolation_output,
	output logic             drive_strength_reduced,
	// Status on ref_clk
	output logic             dll_locked,
	output logic             dll_enabled,
	output logic [3:0]       burst_len_status,
	output logic             burst_type_status
);
	logic [12:0] base_ff, nxt_base;
	logic [12:0] ext_ff, nxt_ext;
	logic        sref_ff, nxt_sref;
	logic [7:0]  lock_ff, nxt_lock;
	logic [7:0]  rdsh_ff, nxt_rdsh;
	logic        rdv_ff, nxt_rdv;
	logic        half_ff, nxt_half;
	logic [2:0]  col_ff, nxt_col;
	logic [2:0]  rcol_ff, nxt_rcol;
	logic        iso_ff, nxt_iso;
	logic        drv_ff, nxt_drv;
	logic        cmd_sel;
	dmc_cmd_e    cmd;
	logic [3:0]  blen;
	logic [2:0]  lat;
	logic        half;
	logic        dll_on;
	logic [5:0]  opm;
	logic [5:0]  s_stat, s_q;
	logic        lk_ff, nxt_lk;
	logic        en_ff, nxt_en;
	logic [3:0]  bl_ff, nxt_bl;
	logic        bt_ff, nxt_bt;

	dmc_burst_if bif ();

	// Command decode on link clock
	always_comb begin
		cmd_sel = !cs_n;
		cmd     = DMC_CMD_NONE;
		if (cmd_sel && !ras_n && !cas_n && !we_n)
			cmd = DMC_CMD_LOAD;
		else if (cmd_sel && ras_n && !cas_n && we_n)
			cmd = DMC_CMD_READ;
		else if (cmd_sel && !ras_n && !cas_n && we_n && !cke)
			cmd = DMC_CMD_SREF;
	end

	// Field decode of base register
	always_comb begin
		opm = base_ff[`DMC_OPM_MSB:`DMC_OPM_LSB];
		case (base_ff[`DMC_BL_MSB:`DMC_BL_LSB])
			`DMC_BL_2: blen = 4'h2;
			`DMC_BL_4: blen = 4'h4;
			`DMC_BL_8: blen = 4'h8;
			default:   blen = 4'h2;
		endcase
		case (base_ff[`DMC_CL_MSB:`DMC_CL_LSB])
			`DMC_CL_2:  begin lat = 3'h2; half = 1'b0; end
			`DMC_CL_25: begin lat = 3'h2; half = 1'b1; end
			`DMC_CL_3:  begin lat = 3'h3; half = 1'b0; end
			default:    begin lat = 3'h2; half = 1'b0; end
		endcase
		dll_on = !ext_ff[`DMC_EXT_DLL_DIS] && !sref_ff;
	end

	// Burst start delayed so the first offset lines up with edge n plus m
	always_comb begin
		bif.start      = rdsh_ff[3'(lat - 3'h2)] && ce;
		bif.interleave = base_ff[`DMC_BT_BIT];
		bif.blen       = blen;
		bif.start_col  = rcol_ff;
	end

	dmc_burst_seq u_seq (
		.ck   (ck),
		.rstn (rstn),
		.ce   (ce),
		.bif  (bif)
	);

	// Next state of link side logic
	always_comb begin
		nxt_base = base_ff;
		nxt_ext  = ext_ff;
		nxt_sref = sref_ff;
		nxt_lock = lock_ff;
		nxt_rdsh = {rdsh_ff[6:0], 1'b0};
		if (cmd == DMC_CMD_LOAD && !bank_select_hi) begin
			if (!bank_select_lo)
				nxt_base = address_inputs;
			else
				nxt_ext = address_inputs;
		end else if (opm == `DMC_OPM_DLL_RST) begin
			nxt_base[`DMC_DLL_RST_BIT] = 1'b0;
		end
		if (cmd == DMC_CMD_SREF)
			nxt_sref = 1'b1;
		else if (sref_ff && cke)
			nxt_sref = 1'b0;
		// Lock counter restarts on DLL reset or while DLL off
		if (!dll_on || opm == `DMC_OPM_DLL_RST)
			nxt_lock = 8'h00;
		else if (lock_ff != 8'(LOCK_CLKS))
			nxt_lock = lock_ff + 8'h01;
		// Read registered at edge n, data at n plus m
		nxt_rcol = rcol_ff;
		if (cmd == DMC_CMD_READ) begin
			nxt_rdsh[0] = 1'b1;
			nxt_rcol    = address_inputs[2:0];
		end
		nxt_rdv  = bif.active;
		nxt_half = half;
		nxt_col  = bif.offset;
		nxt_iso  = ext_ff[`DMC_EXT_ISO] && (bif.active ||
			rdsh_ff[2:0] != 3'h0 || cmd == DMC_CMD_READ);
		nxt_drv  = ext_ff[`DMC_EXT_DRV];
	end

	// Register link side logic
	always_ff @(posedge ck) begin
		if (!rstn) begin
			base_ff <= `DMC_BASE_RST;
			ext_ff  <= `DMC_EXT_RST;
			sref_ff <= 1'b0;
			lock_ff <= 8'h00;
			rdsh_ff <= 8'h00;
			rdv_ff  <= 1'b0;
			half_ff <= 1'b0;
			col_ff  <= 3'h0;
			rcol_ff <= 3'h0;
			iso_ff  <= 1'b0;
			drv_ff  <= 1'b0;
		end else if (ce) begin
			base_ff <= nxt_base;
			ext_ff  <= nxt_ext;
			sref_ff <= nxt_sref;
			lock_ff <= nxt_lock;
			rdsh_ff <= nxt_rdsh;
			rdv_ff  <= nxt_rdv;
			half_ff <= nxt_half;
			col_ff  <= nxt_col;
			rcol_ff <= nxt_rcol;
			iso_ff  <= nxt_iso;
			drv_ff  <= nxt_drv;
		end
	end

	assign rd_data_valid           = rdv_ff;
	assign rd_half_phase           = half_ff;
	assign col_offset              = col_ff;
	assign module_isolation_output = iso_ff;
	assign drive_strength_reduced  = drv_ff;

	// Status levels into ref_clk domain
	assign s_stat = {base_ff[`DMC_BT_BIT], lock_ff == 8'(LOCK_CLKS),
		dll_on, blen[3:1]};

	dmc_sync #(.W(6)) u_sync (
		.clk  (ref_clk),
		.rstn (rstn),
		.d    (s_stat),
		.q    (s_q)
	);

	// Status registers on ref_clk
	always_comb begin
		nxt_lk = s_q[4];
		nxt_en = s_q[3];
		nxt_bl = {s_q[2:0], 1'b0};
		nxt_bt = s_q[5];
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lk_ff <= 1'b0;
			en_ff <= 1'b0;
			bl_ff <= 4'h0;
			bt_ff <= 1'b0;
		end else if (ce) begin
			lk_ff <= nxt_lk;
			en_ff <= nxt_en;
			bl_ff <= nxt_bl;
			bt_ff <= nxt_bt;
		end
	end

	assign dll_locked        = lk_ff;
	assign dll_enabled       = en_ff;
	assign burst_len_status  = bl_ff;
	assign burst_type_status = bt_ff;
endmodule // dmc_ddr_cfg

//--- src/dmc_params.svh
// Offsets, field positions, encodings and timing counts of the config block
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// Base register fields
`define DMC_BL_LSB        0
`define DMC_BL_MSB        2
`define DMC_BT_BIT        3
`define DMC_CL_LSB        4
`define DMC_CL_MSB        6
`define DMC_OPM_LSB       7
`define DMC_OPM_MSB       12
`define DMC_DLL_RST_BIT   8
// Extended register fields
`define DMC_EXT_DLL_DIS   0
`define DMC_EXT_DRV       1
`define DMC_EXT_ISO       2
// Encodings
`define DMC_BL_2          3'h1
`define DMC_BL_4          3'h2
`define DMC_BL_8          3'h3
`define DMC_CL_2          3'h2
`define DMC_CL_25         3'h6
`define DMC_CL_3          3'h3
`define DMC_OPM_NORMAL    6'h00
`define DMC_OPM_DLL_RST   6'h02
// Resets of the two config registers
`define DMC_BASE_RST      13'h0032
`define DMC_EXT_RST       13'h0000
// DLL lock wait in link clocks
`define DMC_LOCK_CLKS     200
`endif

//--- src/dmc_pkg.sv
// Types shared by the config block modules
package dmc_pkg;
	typedef enum logic [1:0] {
		DMC_CMD_NONE,
		DMC_CMD_READ,
		DMC_CMD_LOAD,
		DMC_CMD_SREF
	} dmc_cmd_e;
	typedef logic [12:0] dmc_word_t;
endpackage

//--- src/dmc_burst_if.sv
// Burst request and column offset carrier between config and order logic
`timescale 1ns/1ps
interface dmc_burst_if;
	logic       start;
	logic       interleave;
	logic [3:0] blen;
	logic [2:0] start_col;
	logic [2:0] offset;
	logic       active;
	modport ctl (output start, interleave, blen, start_col,
		input offset, active);
	modport seq (input start, interleave, blen, start_col,
		output offset, active);
endinterface

//--- src/dmc_burst_seq.sv
// Column offset sequencer for sequential and interleaved bursts
`timescale 1ns/1ps
module dmc_burst_seq
	import dmc_pkg::*;
(
	// Clock and control
	input  wire logic ck,
	input  wire logic rstn,
	input  wire logic ce,
	// Burst carrier
	dmc_burst_if.seq  bif
);
	logic [2:0] cnt_ff, nxt_cnt;
	logic [2:0] st_ff, nxt_st;
	logic [2:0] msk_ff, nxt_msk;
	logic       il_ff, nxt_il;
	logic       act_ff, nxt_act;
	logic [2:0] base_off;

	// Offset within block: add or xor k, wrapped by mask
	always_comb begin
		if (il_ff)
			base_off = st_ff ^ cnt_ff;
		else
			base_off = (st_ff + cnt_ff) & msk_ff;
		bif.offset = base_off & msk_ff;
		bif.active = act_ff;
	end

	// Next burst state
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_st  = st_ff;
		nxt_msk = msk_ff;
		nxt_il  = il_ff;
		nxt_act = act_ff;
		if (bif.start) begin
			nxt_msk = 3'(bif.blen - 4'h1);
			nxt_st  = bif.start_col & 3'(bif.blen - 4'h1);
			nxt_il  = bif.interleave;
			nxt_cnt = 3'h0;
			nxt_act = 1'b1;
		end else if (act_ff) begin
			nxt_cnt = cnt_ff + 3'h1;
			if (cnt_ff == msk_ff)
				nxt_act = 1'b0;
		end
	end

	// Register burst state
	always_ff @(posedge ck) begin
		if (!rstn) begin
			cnt_ff <= 3'h0;
			st_ff  <= 3'h0;
			msk_ff <= 3'h0;
			il_ff  <= 1'b0;
			act_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
			st_ff  <= nxt_st;
			msk_ff <= nxt_msk;
			il_ff  <= nxt_il;
			act_ff <= nxt_act;
		end
	end
endmodule // dmc_burst_seq

//--- src/dmc_sync.sv
// Two-flop level synchroniser into the register clock domain
`timescale 1ns/1ps
module dmc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Data
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] s1_ff, s2_ff;

	// Two stages, first read only by second
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
		end
	end
	assign q = s2_ff;
endmodule // dmc_sync

//--- sim/dmc_ddr_cfg_props.sv
// Link-side checks of the config block
`timescale 1ns/1ps
`include "dmc_params.svh"
module dmc_ddr_cfg_props (
	// Link pins
	input wire logic        ck,
	input wire logic        rstn,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        bank_select_lo,
	input wire logic        bank_select_hi,
	input wire logic [12:0] address_inputs,
	// Outputs
	input wire logic        rd_data_valid,
	input wire logic        rd_half_phase,
	input wire logic [2:0]  col_offset,
	input wire logic        module_isolation_output,
	input wire logic        drive_strength_reduced
);
	wire ld = !cs_n && !ras_n && !cas_n && !we_n && !bank_select_hi;
	wire rd = !cs_n && ras_n && !cas_n && we_n;
	logic [12:0] base_ff;
	logic [2:0]  ext_ff, st_ff;
	logic [3:0]  beat_ff;
	wire  [2:0]  bl = base_ff[2:0];
	wire  [2:0]  msk = bl == 3'h3 ? 3'h7 : bl == 3'h2 ? 3'h3 : 3'h1;
	// Shadow registers, start offset and beat count
	always_ff @(posedge ck) begin
		if (!rstn) begin
			base_ff <= `DMC_BASE_RST;
			ext_ff <= 3'h0;
			st_ff <= 3'h0;
			beat_ff <= 4'h0;
		end else begin
			if (ld && !bank_select_lo)
				base_ff <= address_inputs;
			if (ld && bank_select_lo)
				ext_ff <= address_inputs[2:0];
			if (rd)
				st_ff <= address_inputs[2:0] & msk;
			beat_ff <= rd_data_valid ? beat_ff + 4'h1 : 4'h0;
		end
	end
	default clocking dc @(posedge ck); endclocking
	default disable iff (!rstn);
	sequence rd_cl(c);
		rd && base_ff[6:4] == c;
	endsequence
	chk_lat_two: assert property (rd_cl(3'h2) |->
		##2 !rd_data_valid ##1 rd_data_valid) else $error("bad latency");
	chk_lat_half: assert property (rd_cl(3'h6) |->
		##2 !rd_data_valid ##1 rd_data_valid) else $error("bad latency");
	chk_half_flag: assert property (rd_data_valid |->
		rd_half_phase == (base_ff[6:4] == 3'h6)) else $error("bad half");
	chk_burst_len: assert property ($fell(rd_data_valid) |->
		beat_ff == {1'b0, msk} + 4'h1) else $error("bad length");
	chk_seq_order: assert property (rd_data_valid && !base_ff[3] |->
		col_offset == ((st_ff + beat_ff[2:0]) & msk)) else $error("bad beat");
	chk_ilv_order: assert property (rd_data_valid && base_ff[3] |->
		col_offset == (st_ff ^ beat_ff[2:0])) else $error("bad beat");
	chk_iso_gate: assert property (module_isolation_output |->
		ext_ff[2]) else $error("isolation not enabled");
	chk_drive_bit: assert property (!$past(ld) && !$past(ld, 2) |->
		drive_strength_reduced == ext_ff[1]) else $error("bad drive");
endmodule // dmc_ddr_cfg_props
bind dmc_ddr_cfg dmc_ddr_cfg_props i_dmc_ddr_cfg_props (.ck, .rstn, .cs_n,
	.ras_n, .cas_n, .we_n, .bank_select_lo, .bank_select_hi, .address_inputs,
	.rd_data_valid, .rd_half_phase, .col_offset, .module_isolation_output,
	.drive_strength_reduced);

//--- sim/dmc_ctl_model.sv
// Memory controller model issuing commands on the link clock
`timescale 1ns/1ps
module dmc_ctl_model (
	// Link clock
	input wire logic ck,
	// Command pins
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic        bank_select_lo,
	output logic        bank_select_hi,
	output logic [12:0] address_inputs
);
	// Deselected at time zero
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		{bank_select_hi, bank_select_lo} = 2'h0;
		address_inputs = 13'h0000;
	end
	// One command edge, then deselect with the address scrambled
	task automatic issue(input logic [3:0] c, input logic [1:0] ba,
		input logic [12:0] a);
		@(posedge ck);
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_hi, bank_select_lo} <= ba;
		address_inputs <= a;
		@(posedge ck);
		cs_n <= 1'b1;
		address_inputs <= ~a;
	endtask
	// Config load between bursts only, then the post-load wait
	task automatic load(input logic [1:0] ba, input logic [12:0] a);
		issue(4'h0, ba, a);
		repeat (2) @(posedge ck);
	endtask
	// Column read, issued once the lock wait has run
	task automatic read(input logic [12:0] a);
		issue(4'h5, 2'h0, a);
	endtask
endmodule // dmc_ctl_model

//--- sim/dmc_ddr_cfg_tb.sv
// Self-checking bench of the config block
`timescale 1ns/1ps
module dmc_ddr_cfg_tb;
	logic        ref_clk, ck, rstn;
	logic        cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi;
	logic [12:0] address_inputs;
	logic        rd_data_valid, rd_half_phase, dll_locked, dll_enabled;
	logic        module_isolation_output, drive_strength_reduced;
	logic        burst_type_status;
	logic [2:0]  col_offset;
	logic [3:0]  burst_len_status;
	int          n_fail, checks;
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", n, e, a); end end
	dmc_ddr_cfg #(.LOCK_CLKS(8)) i_dmc_ddr_cfg (.ref_clk, .rstn, .ce(1'b1),
		.ck, .cs_n, .ras_n, .cas_n, .we_n, .cke(1'b1), .bank_select_lo,
		.bank_select_hi, .address_inputs, .rd_data_valid, .rd_half_phase,
		.col_offset, .module_isolation_output, .drive_strength_reduced,
		.dll_locked, .dll_enabled, .burst_len_status, .burst_type_status);
	dmc_ctl_model i_dmc_ctl_model (.ck, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select_lo, .bank_select_hi, .address_inputs);
	// Verdict and end of run
	task automatic summarize;
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Load a mode, read once, follow every beat
	task automatic burst(input logic [2:0] bc, input logic t,
		input logic [2:0] cl);
		logic [2:0] m;
		logic [2:0] s;
		int n;
		m = bc == 3'h3 ? 3'h7 : bc == 3'h2 ? 3'h3 : 3'h1;
		s = 3'h5 & m;
		i_dmc_ctl_model.load(2'h0, {6'h00, cl, t, bc});
		i_dmc_ctl_model.read({10'h01F, s});
		n = 0;
		while (rd_data_valid !== 1'b1 && n < 8) begin
			@(negedge ck);
			n++;
		end
		for (int k = 0; k <= m; k++) begin
			`CHK("valid", 1'b1, rd_data_valid)
			`CHK("beat", t ? s ^ k[2:0] : (s + k[2:0]) & m, col_offset)
			`CHK("half", cl == 3'h6, rd_half_phase)
			`CHK("iso", 1'b1, module_isolation_output)
			@(negedge ck);
		end
		`CHK("end", 1'b0, rd_data_valid)
		repeat (12) @(negedge ck);
		`CHK("len", {1'b0, m} + 4'h1, burst_len_status)
		`CHK("idle iso", 1'b0, module_isolation_output)
		`CHK("type", t, burst_type_status)
	endtask
	// Register clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Link clock, phase unrelated
	initial begin
		ck = 1'b0;
		#7;
		forever #6 ck = ~ck;
	end
	// Watchdog far beyond the expected run
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
	// Main sequence
	initial begin
		n_fail = 0;
		checks = 0;
		rstn = 1'b0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		i_dmc_ctl_model.load(2'h1, 13'h0006);
		i_dmc_ctl_model.load(2'h0, 13'h0122);
		i_dmc_ctl_model.load(2'h0, 13'h0022);
		i_dmc_ctl_model.load(2'h2, 13'h0033);
		repeat (30) @(negedge ck);
		`CHK("len hold", 4'h4, burst_len_status)
		`CHK("dll on", 1'b1, dll_enabled)
		`CHK("locked", 1'b1, dll_locked)
		for (int i = 0; i < 16; i++) begin
			burst({1'b0, i[1:0]}, i[2], i[3] ? 3'h6 : 3'h2);
		end
		`CHK("drive", 1'b1, drive_strength_reduced)
		summarize();
	end
endmodule // dmc_ddr_cfg_tb
